// [rtl/pspt_lane.sv]
// One serial slot lane: parallel word out, serial bits in, MSB first
`timescale 1ns/100ps
module pspt_lane #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Timing
  input wire logic sample,
  input wire logic in_slot,
  input wire logic clear,
  input wire logic [4:0] len,
  // Data
  input wire logic serial_in,
  input wire logic [W-1:0] tx_word,
  output logic tx_bit,
  output logic [W-1:0] rx_word
);
  logic [W-1:0] shreg;
  logic [W-1:0] next_shreg;
  logic [4:0] cnt;
  logic [4:0] shamt;

  // Word is left aligned so the first slot bit sits at the top
  assign shamt = 5'(W) - len;
  assign next_shreg = {shreg[W-2:0], serial_in};
  assign tx_bit = shreg[W-1];

  // Shift while in slot, reload the outgoing word between slots
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg <= '0;
      cnt <= '0;
    end else if (sample) begin
      if (in_slot) begin
        shreg <= next_shreg;
        cnt <= cnt + 5'h01;
      end else begin
        shreg <= tx_word << shamt;
        cnt <= '0;
      end
    end
  end

  // Received word lands when the slot's last bit is in
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      rx_word <= '0;
    end else if (sample && in_slot && (cnt == len - 5'h01)) begin
      rx_word <= next_shreg & ~({W{1'b1}} << len);
    end
  end
endmodule

// [rtl/pspt_pkg.sv]
// Shared constants and types of the PCM serial port timing block
package pspt_pkg;
  // Frame timing in aclk cycles; a bit cell is two cycles
  localparam logic [8:0] LAST_CYC = 9'h1FF;
  localparam int BIT_CELL = 2;
  localparam logic PH_SAMPLE = 1'b0;
  localparam logic PH_LAUNCH = 1'b1;
  localparam logic [8:0] DLY_COMP = 9'h040;
  localparam logic [8:0] DLY_LIN = 9'h080;
  localparam logic [9:0] LOW_LIMIT = 10'h200;
  // Slot lengths in bits
  localparam logic [4:0] LEN_COMP = 5'h08;
  localparam logic [4:0] LEN_LIN = 5'h10;
  localparam logic [4:0] LEN_DC = 5'h08;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TX_PCM1 = 8'h08;
  localparam logic [7:0] OFS_TX_PCM2 = 8'h0C;
  localparam logic [7:0] OFS_TX_ADPCM = 8'h10;
  localparam logic [7:0] OFS_RX_PCM1 = 8'h14;
  localparam logic [7:0] OFS_RX_PCM2 = 8'h18;
  localparam logic [7:0] OFS_RX_ADPCM = 8'h1C;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Encoder mode codes
  typedef enum logic [2:0] {
    ENC_32K = 3'b000,
    ENC_24K = 3'b001,
    ENC_16K = 3'b010,
    ENC_ABYP = 3'b011,
    ENC_ABYP16 = 3'b100,
    ENC_PBYP = 3'b101,
    ENC_ARST = 3'b110,
    ENC_ODIS = 3'b111
  } pspt_enc_mode_t;
  typedef enum logic {
    PORT_FRAME_SYNC = 1'b0,
    PORT_STROBED = 1'b1
  } pspt_port_mode_t;
  // Control register layout, low five bits
  typedef struct packed {
    logic encoder_mode_bit2;
    logic encoder_mode_bit1;
    logic encoder_mode_bit0;
    logic sel;
    logic linear;
  } pspt_ctrl_t;
  localparam pspt_ctrl_t CTRL_RESET = 5'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage

// [rtl/pspt_top.sv]
// PCM serial port timing: frame counter, strobes, serial lanes, bus slave
`timescale 1ns/100ps
module pspt_top #(
  parameter int ADDR_W = 8,
  parameter logic [4:0] CH_B1 = 5'h00,
  parameter logic [4:0] CH_B2 = 5'h02,
  parameter logic [4:0] CH_D = 5'h04,
  parameter logic [4:0] CH_C = 5'h05
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Timing pins
  input wire logic frame_pulse_in_n,
  input wire logic bit_clock_in,
  input wire logic slot1_strobe_in,
  input wire logic slot2_strobe_in,
  output logic slot1_strobe_out,
  output logic slot1_strobe_oe_n,
  output logic slot2_strobe_out,
  output logic slot2_strobe_oe_n,
  output logic half_rate_bit_clock_out,
  output logic half_rate_bit_clock_oe_n,
  output logic delayed_frame_pulse_out_n,
  output logic delayed_frame_oe_n,
  // Serial data pins
  input wire logic pcm_in_port1,
  input wire logic pcm_in_port2,
  input wire logic compressed_in,
  output logic pcm_out_port1,
  output logic pcm_out_port1_oe_n,
  output logic pcm_out_port2,
  output logic pcm_out_port2_oe_n,
  output logic compressed_out,
  output logic compressed_out_oe_n
);
  pspt_pkg::pspt_ctrl_t ctrl;
  pspt_pkg::pspt_enc_mode_t enc_mode;
  pspt_pkg::pspt_port_mode_t port_mode;
  logic [15:0] tx_pcm1, tx_pcm2, tx_adpcm;
  logic [15:0] rx_pcm1, rx_pcm2, rx_adpcm;
  logic [15:0] word1, word2, word_a;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [7:0] wa, ra;
  logic wr_fire, wr_ok, rd_err;
  logic [31:0] rd_data;
  logic fp_prev, bc_prev, frame_start, fs, linear, sel;
  logic [9:0] low_cnt;
  logic [8:0] cyc, dly;
  logic [7:0] bit_idx, idx_nx;
  logic phase, bc_rise, bc_fall, launch, sample;
  logic [4:0] len;
  logic s1_now, s2_now, s1_nx, s2_nx, cmp_now, cmp_nx;
  logic s1_hit_nx, s2_hit_nx, s1_first_nx, dc_now, dc_nx, dc_drive, dc_off, dc_bit;
  logic abyp, pbyp, arst, odis, m16, sel16;
  logic tx_bit1, tx_bit2, tx_bit_a;

  // True when idx falls in the slot starting at channel ch
  function automatic logic slot_hit(input logic [7:0] idx, input logic [4:0] ch,
                                    input logic [4:0] n);
    logic [8:0] base;
    base = {1'b0, ch, 3'h0};
    slot_hit = ({1'b0, idx} >= base) && ({1'b0, idx} < base + {4'h0, n});
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] st);
    merge16 = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
  endfunction

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= pspt_pkg::RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? pspt_pkg::RESP_OKAY : pspt_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  assign wr_fire = !awready && !wready && !bvalid;
  assign wa = {aw_addr[7:2], 2'b00};
  assign ra = {araddr[7:2], 2'b00};
  assign wr_ok = (wa <= pspt_pkg::OFS_RX_ADPCM);

  // Register writes; status and receive words ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= pspt_pkg::CTRL_RESET;
      tx_pcm1 <= pspt_pkg::WORD_RESET;
      tx_pcm2 <= pspt_pkg::WORD_RESET;
      tx_adpcm <= pspt_pkg::WORD_RESET;
    end else if (wr_fire) begin
      if (wa == pspt_pkg::OFS_CTRL && w_strb[0]) begin
        ctrl <= pspt_pkg::pspt_ctrl_t'(w_data[4:0]);
      end
      if (wa == pspt_pkg::OFS_TX_PCM1) begin
        tx_pcm1 <= merge16(tx_pcm1, w_data[15:0], w_strb[1:0]);
      end
      if (wa == pspt_pkg::OFS_TX_PCM2) begin
        tx_pcm2 <= merge16(tx_pcm2, w_data[15:0], w_strb[1:0]);
      end
      if (wa == pspt_pkg::OFS_TX_ADPCM) begin
        tx_adpcm <= merge16(tx_adpcm, w_data[15:0], w_strb[1:0]);
      end
    end
  end

  // Read decode; unmapped words answer zero with an error
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    case (ra)
      pspt_pkg::OFS_CTRL: rd_data = {27'h0, ctrl};
      pspt_pkg::OFS_STATUS: rd_data = {23'h0, bit_idx, !fs};
      pspt_pkg::OFS_TX_PCM1: rd_data = {16'h0000, tx_pcm1};
      pspt_pkg::OFS_TX_PCM2: rd_data = {16'h0000, tx_pcm2};
      pspt_pkg::OFS_TX_ADPCM: rd_data = {16'h0000, tx_adpcm};
      pspt_pkg::OFS_RX_PCM1: rd_data = {16'h0000, rx_pcm1};
      pspt_pkg::OFS_RX_PCM2: rd_data = {16'h0000, rx_pcm2};
      pspt_pkg::OFS_RX_ADPCM: rd_data = {16'h0000, rx_adpcm};
      default: rd_err = 1'b1;
    endcase
  end

  // Read channel, one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= pspt_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_err ? pspt_pkg::RESP_SLVERR : pspt_pkg::RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Encoder mode decode; all eight codes are legal
  assign enc_mode = pspt_pkg::pspt_enc_mode_t'({ctrl.encoder_mode_bit2,
                                                ctrl.encoder_mode_bit1,
                                                ctrl.encoder_mode_bit0});
  always_comb begin
    abyp = 1'b0;
    pbyp = 1'b0;
    arst = 1'b0;
    odis = 1'b0;
    m16 = 1'b0;
    unique case (enc_mode)
      pspt_pkg::ENC_32K, pspt_pkg::ENC_24K: begin
        m16 = 1'b0;
      end
      pspt_pkg::ENC_16K: m16 = 1'b1;
      pspt_pkg::ENC_ABYP: abyp = 1'b1;
      pspt_pkg::ENC_ABYP16: begin
        abyp = 1'b1;
        m16 = 1'b1;
      end
      pspt_pkg::ENC_PBYP: pbyp = 1'b1;
      pspt_pkg::ENC_ARST: arst = 1'b1;
      pspt_pkg::ENC_ODIS: odis = 1'b1;
    endcase
  end

  // Pin mode: a frame pulse held low a whole frame means strobed operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fp_prev <= 1'b1;
      bc_prev <= 1'b0;
      low_cnt <= '0;
      port_mode <= pspt_pkg::PORT_FRAME_SYNC;
    end else begin
      fp_prev <= frame_pulse_in_n;
      bc_prev <= bit_clock_in;
      if (frame_pulse_in_n) begin
        low_cnt <= '0;
        port_mode <= pspt_pkg::PORT_FRAME_SYNC;
      end else if (low_cnt != pspt_pkg::LOW_LIMIT) begin
        low_cnt <= low_cnt + 10'h001;
      end else begin
        port_mode <= pspt_pkg::PORT_STROBED;
      end
    end
  end

  assign fs = (port_mode == pspt_pkg::PORT_FRAME_SYNC);
  assign frame_start = frame_pulse_in_n && !fp_prev;

  // Frame cycle counter, restarted by the end of each frame pulse; reset parks it
  // on the last cycle so the first slot after release is a whole one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc <= pspt_pkg::LAST_CYC;
    end else if (frame_start || cyc == pspt_pkg::LAST_CYC) begin
      cyc <= '0;
    end else begin
      cyc <= cyc + 9'h001;
    end
  end

  assign linear = ctrl.linear;
  assign sel = ctrl.sel;
  assign phase = cyc[0];
  assign bit_idx = cyc[8:1];
  assign idx_nx = bit_idx + 8'h01;
  assign len = linear ? pspt_pkg::LEN_LIN : pspt_pkg::LEN_COMP;
  assign dly = linear ? pspt_pkg::DLY_LIN : pspt_pkg::DLY_COMP;
  // Bit clock edges; in frame-sync mode it is held low and unused
  assign bc_rise = bit_clock_in && !bc_prev;
  assign bc_fall = !bit_clock_in && bc_prev;
  // Launch ends a cell, sample at its middle; strobed mode follows the pin
  assign launch = fs ? (phase == pspt_pkg::PH_LAUNCH) : bc_rise;
  assign sample = fs ? (phase == pspt_pkg::PH_SAMPLE) : bc_fall;

  // Slot windows: counted in frame-sync mode, strobe pins in strobed mode
  assign s1_hit_nx = slot_hit(idx_nx, CH_B1, len);
  assign s2_hit_nx = slot_hit(idx_nx, CH_B2, len);
  assign s1_first_nx = (idx_nx == {CH_B1, 3'h0});
  assign s1_now = fs ? slot_hit(bit_idx, CH_B1, len) : slot1_strobe_in;
  assign s2_now = fs ? slot_hit(bit_idx, CH_B2, len) : slot2_strobe_in;
  assign s1_nx = fs ? s1_hit_nx : slot1_strobe_in;
  assign s2_nx = fs ? s2_hit_nx : slot2_strobe_in;
  assign sel16 = m16 && sel;
  assign cmp_now = sel16 ? s2_now : s1_now;
  assign cmp_nx = sel16 ? s2_nx : s1_nx;
  assign dc_now = fs && (slot_hit(bit_idx, CH_D, pspt_pkg::LEN_DC) ||
                         slot_hit(bit_idx, CH_C, pspt_pkg::LEN_DC));
  assign dc_nx = fs && (slot_hit(idx_nx, CH_D, pspt_pkg::LEN_DC) ||
                        slot_hit(idx_nx, CH_C, pspt_pkg::LEN_DC));
  assign dc_drive = dc_nx && !slot1_strobe_in;
  assign dc_off = dc_nx && slot1_strobe_in && !s1_nx;

  // Bypass routing: PCM bypass picks a port by select, ADPCM bypass loops back
  assign word1 = (pbyp && !sel) ? rx_adpcm : tx_pcm1;
  assign word2 = (pbyp && sel) ? rx_adpcm : tx_pcm2;
  assign word_a = abyp ? rx_adpcm : pbyp ? (sel ? rx_pcm2 : rx_pcm1) : tx_adpcm;

  pspt_lane #(.W(16)) u_lane1 (
    .aclk(aclk), .aresetn(aresetn), .sample(sample), .in_slot(s1_now), .clear(arst),
    .len(len), .serial_in(pcm_in_port1), .tx_word(word1), .tx_bit(tx_bit1),
    .rx_word(rx_pcm1)
  );
  pspt_lane #(.W(16)) u_lane2 (
    .aclk(aclk), .aresetn(aresetn), .sample(sample), .in_slot(s2_now), .clear(arst),
    .len(len), .serial_in(pcm_in_port2), .tx_word(word2), .tx_bit(tx_bit2),
    .rx_word(rx_pcm2)
  );
  pspt_lane #(.W(16)) u_lane_a (
    .aclk(aclk), .aresetn(aresetn), .sample(sample), .in_slot(cmp_now), .clear(arst),
    .len(len), .serial_in(compressed_in), .tx_word(word_a), .tx_bit(tx_bit_a),
    .rx_word(rx_adpcm)
  );

  // D and C bits are retransmitted one cell late, the cost of a single flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dc_bit <= 1'b0;
    end else if (sample && dc_now) begin
      dc_bit <= pcm_in_port1;
    end
  end

  // Serial outputs change only at launch and float outside their slots
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcm_out_port1 <= 1'b0;
      pcm_out_port1_oe_n <= 1'b1;
      pcm_out_port2 <= 1'b0;
      pcm_out_port2_oe_n <= 1'b1;
      compressed_out <= 1'b0;
      compressed_out_oe_n <= 1'b1;
    end else if (launch) begin
      pcm_out_port1 <= dc_drive ? dc_bit : tx_bit1;
      pcm_out_port1_oe_n <= !(s1_nx || dc_drive);
      pcm_out_port2 <= tx_bit2;
      pcm_out_port2_oe_n <= !s2_nx;
      compressed_out <= tx_bit_a;
      compressed_out_oe_n <= !(cmp_nx && !odis);
    end
  end

  // Strobe, clock and frame outputs; all float in strobed mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot1_strobe_out <= 1'b0;
      slot1_strobe_oe_n <= 1'b1;
      slot2_strobe_out <= 1'b0;
      slot2_strobe_oe_n <= 1'b1;
      half_rate_bit_clock_out <= 1'b0;
      half_rate_bit_clock_oe_n <= 1'b1;
      delayed_frame_pulse_out_n <= 1'b1;
      delayed_frame_oe_n <= 1'b1;
    end else begin
      slot1_strobe_oe_n <= !fs;
      if (!fs) begin
        slot1_strobe_out <= 1'b0;
      end else if (launch) begin
        slot1_strobe_out <= linear ? s1_first_nx : s1_hit_nx;
      end
      slot2_strobe_oe_n <= !(fs && !linear);
      if (!fs || linear) begin
        slot2_strobe_out <= 1'b0;
      end else if (launch) begin
        slot2_strobe_out <= s2_hit_nx;
      end
      // High in the first half of each cell; a frame start forces the next cell's
      // first half, so a late frame pulse realigns the clock at once
      half_rate_bit_clock_out <= fs && (frame_start || phase == pspt_pkg::PH_LAUNCH);
      half_rate_bit_clock_oe_n <= !fs;
      delayed_frame_pulse_out_n <= !(fs && cyc == dly);
      delayed_frame_oe_n <= !fs;
    end
  end

  // Checks
  localparam int DFP_WAIT_COMP = 66;
  localparam int DFP_WAIT_LIN = 130;
  logic [4:0] hi_cnt;
  logic odis_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !slot1_strobe_out) begin
      hi_cnt <= '0;
    end else begin
      hi_cnt <= hi_cnt + 5'h01;
    end
  end
  assign odis_q = odis;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_strobe1_width: assert property (fs && !linear && $fell(slot1_strobe_out)
    |-> hi_cnt == 5'(pspt_pkg::LEN_COMP * pspt_pkg::BIT_CELL))
    else $error("slot 1 strobe not eight bits wide");
  a_strobe1_pulse: assert property (fs && linear && $fell(slot1_strobe_out)
    |-> hi_cnt == 5'(pspt_pkg::BIT_CELL))
    else $error("slot 1 strobe not one bit in linear mode");
  a_strobe1_float: assert property (!fs |=> slot1_strobe_oe_n && !slot1_strobe_out)
    else $error("slot 1 strobe driven in strobed mode");
  a_hclk_float: assert property (!fs |=> half_rate_bit_clock_oe_n)
    else $error("half rate clock driven in strobed mode");
  a_hclk_align: assert property (fs && frame_start |=> half_rate_bit_clock_out
    ##1 !half_rate_bit_clock_out)
    else $error("half rate clock not aligned to frame");
  a_dfp_comp: assert property (fs && !linear && frame_start
    |-> ##DFP_WAIT_COMP !delayed_frame_pulse_out_n)
    else $error("delayed frame pulse not 64 cycles late");
  a_dfp_lin: assert property (fs && linear && frame_start
    |-> ##DFP_WAIT_LIN !delayed_frame_pulse_out_n)
    else $error("delayed frame pulse not 128 cycles late");
  a_mode_return: assert property (frame_pulse_in_n |=> fs)
    else $error("high frame pulse did not select frame-sync mode");
  a_fs_launch: assert property (fs && $past(fs) && $changed(pcm_out_port2)
    |-> $past(launch) && $past(phase) == pspt_pkg::PH_LAUNCH)
    else $error("frame-sync output changed off its launch phase");
  a_ss_launch: assert property (!fs && $past(!fs) && $changed(pcm_out_port2)
    |-> $past(bc_rise))
    else $error("strobed output changed off a rising bit clock");
  a_dc_float: assert property ($past(launch) && $past(dc_off) |-> pcm_out_port1_oe_n)
    else $error("D/C slot driven while slot 1 input high");
  a_out_disable: assert property ($past(launch) && $past(odis_q) |-> compressed_out_oe_n)
    else $error("compressed output driven while disabled");
endmodule

// [verification/pspt_codec_model.sv]
// Far-side codec model: frame pulse, bit clock, strobes and serial loopback
`timescale 1ns/100ps
module pspt_codec_model (
  // Clock, reset and port mode
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic strobed,
  // Device serial outputs
  input wire logic pcm_out_port1,
  input wire logic pcm_out_port1_oe_n,
  input wire logic pcm_out_port2,
  input wire logic pcm_out_port2_oe_n,
  input wire logic compressed_out,
  input wire logic compressed_out_oe_n,
  // Device timing and serial inputs
  output logic frame_pulse_in_n,
  output logic bit_clock_in,
  output logic slot1_strobe_in,
  output logic slot2_strobe_in,
  output logic pcm_in_port1,
  output logic pcm_in_port2,
  output logic compressed_in
);
  logic [8:0] cnt;
  logic [2:0] last;
  logic [4:0] bit_idx;
  assign bit_idx = cnt[8:4];
  // Free-running position; one strobed bit lasts 16 aclk cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 9'h000;
      last <= 3'h0;
    end else begin
      cnt <= cnt + 9'h001;
      last <= {compressed_in, pcm_in_port2, pcm_in_port1};
    end
  end
  // One low cycle per 512, or held low to ask for strobed mode
  assign frame_pulse_in_n = strobed ? 1'b0 : (cnt != 9'h1FF);
  // Clock runs for 16 bits then stands still; low in frame-sync mode
  assign bit_clock_in = strobed && (bit_idx < 5'h10) && !cnt[3];
  // Strobes change at rising bit clock, so they are settled at the fall
  assign slot1_strobe_in = strobed && (bit_idx < 5'h08);
  assign slot2_strobe_in = strobed && bit_idx[4:3] == 2'h1;
  // Loopback; a released line toggles so a stale bit never looks valid
  assign pcm_in_port1 = pcm_out_port1_oe_n ? ~last[0] : pcm_out_port1;
  assign pcm_in_port2 = pcm_out_port2_oe_n ? ~last[1] : pcm_out_port2;
  assign compressed_in = compressed_out_oe_n ? ~last[2] : compressed_out;
endmodule

// [verification/tb_pspt_top.sv]
// Self-checking bench for the PCM serial port timing block
`timescale 1ns/100ps
module tb_pspt_top;
  typedef struct {logic [7:0] a; logic [31:0] w, r; logic [1:0] br, rr;} pspt_row_t;
  logic aclk = 0, aresetn = 0, strobed = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic frame_pulse_in_n, bit_clock_in, slot1_strobe_in, slot2_strobe_in;
  logic pcm_in_port1, pcm_in_port2, compressed_in;
  logic slot1_strobe_out, slot1_strobe_oe_n, slot2_strobe_out, slot2_strobe_oe_n;
  logic half_rate_bit_clock_out, half_rate_bit_clock_oe_n;
  logic delayed_frame_pulse_out_n, delayed_frame_oe_n;
  logic pcm_out_port1, pcm_out_port1_oe_n, pcm_out_port2, pcm_out_port2_oe_n;
  logic compressed_out, compressed_out_oe_n;
  logic fp_prev = 1, hc_prev = 0, hoe_prev = 1;
  int fcnt = 0, dly = 0, s1cnt = 0, s1w = 0, s2cnt = 0, s2w = 0, hbad = 0, cdrv = 0, base;
  int miscompares = 0, n_checks = 0;
  pspt_row_t rows [5] = '{
    '{8'h08, 32'hFFFF_00A5, 32'h0000_00A5, 2'h0, 2'h0},
    '{8'h0C, 32'h0000_003C, 32'h0000_003C, 2'h0, 2'h0},
    '{8'h10, 32'h0000_005A, 32'h0000_005A, 2'h0, 2'h0},
    '{8'h24, 32'h0000_1234, 32'h0000_0000, 2'h2, 2'h2},
    '{8'h00, 32'hFFFF_FFE0, 32'h0000_0000, 2'h0, 2'h0}};

  pspt_top pspt_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .frame_pulse_in_n, .bit_clock_in, .slot1_strobe_in,
    .slot2_strobe_in, .slot1_strobe_out, .slot1_strobe_oe_n, .slot2_strobe_out,
    .slot2_strobe_oe_n, .half_rate_bit_clock_out, .half_rate_bit_clock_oe_n,
    .delayed_frame_pulse_out_n, .delayed_frame_oe_n, .pcm_in_port1, .pcm_in_port2,
    .compressed_in, .pcm_out_port1, .pcm_out_port1_oe_n, .pcm_out_port2,
    .pcm_out_port2_oe_n, .compressed_out, .compressed_out_oe_n);
  pspt_codec_model pspt_codec_model_i (.aclk, .aresetn, .strobed, .pcm_out_port1,
    .pcm_out_port1_oe_n, .pcm_out_port2, .pcm_out_port2_oe_n, .compressed_out,
    .compressed_out_oe_n, .frame_pulse_in_n, .bit_clock_in, .slot1_strobe_in,
    .slot2_strobe_in, .pcm_in_port1, .pcm_in_port2, .compressed_in);

  // 25 MHz master clock, well above the transcoder minimum
  always #20 aclk = ~aclk;

  // Monitors: frame delay, strobe width, half-rate clock and drive counts
  always @(posedge aclk) begin
    fp_prev <= frame_pulse_in_n;
    fcnt <= (frame_pulse_in_n && !fp_prev) ? 1 : fcnt + 1;
    if (!delayed_frame_pulse_out_n && !delayed_frame_oe_n) dly <= fcnt;
    if (slot1_strobe_out && !slot1_strobe_oe_n) s1cnt <= s1cnt + 1;
    else if (s1cnt != 0) begin
      s1w <= s1cnt;
      s1cnt <= 0;
    end
    if (slot2_strobe_out && !slot2_strobe_oe_n) s2cnt <= s2cnt + 1;
    else if (s2cnt != 0) begin
      s2w <= s2cnt;
      s2cnt <= 0;
    end
    hc_prev <= half_rate_bit_clock_out;
    hoe_prev <= half_rate_bit_clock_oe_n;
    if (!hoe_prev && !half_rate_bit_clock_oe_n && hc_prev === half_rate_bit_clock_out) begin
      hbad <= hbad + 1;
    end
    if (!compressed_out_oe_n) cdrv <= cdrv + 1;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // Read: rready held until the answer is sampled
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Control changes land mid-frame, clear of the strobe and frame delay windows
  task automatic mid_frame();
    @(negedge delayed_frame_pulse_out_n);
    repeat (100) @(posedge aclk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Whole run is under 6000 cycles; over three times that means a hang
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].w, r);
      chk("bresp", r, rows[i].br);
      axr(rows[i].a, d, r);
      chk("rdata", d, rows[i].r);
      chk("rresp", r, rows[i].rr);
    end
    $display("test registers done");
    repeat (1100) @(posedge aclk);
    axr(pspt_pkg::OFS_RX_PCM1, d, r);
    chk("rx_pcm1", d, 32'h0000_00A5);
    axr(pspt_pkg::OFS_RX_PCM2, d, r);
    chk("rx_pcm2", d, 32'h0000_003C);
    axr(pspt_pkg::OFS_RX_ADPCM, d, r);
    chk("rx_adpcm", d, 32'h0000_005A);
    chk("frame_delay", dly, 66);
    chk("strobe1_width", s1w, 16);
    chk("half_clock_bad", hbad, 0);
    chk("strobe2_width", s2w, 16);
    $display("test frame sync done");
    mid_frame();
    axw(pspt_pkg::OFS_CTRL, 32'h0000_0001, r);
    repeat (1100) @(posedge aclk);
    chk("strobe1_width", s1w, 2);
    chk("frame_delay", dly, 130);
    chk("strobe2_oe_n", slot2_strobe_oe_n, 1);
    axr(pspt_pkg::OFS_RX_PCM1, d, r);
    chk("rx_pcm1", d, 32'h0000_00A5);
    $display("test linear done");
    mid_frame();
    for (int m = 0; m < 8; m++) begin
      axw(pspt_pkg::OFS_CTRL, 32'(m) << 2, r);
      axr(pspt_pkg::OFS_CTRL, d, r);
      chk("ctrl_mode", d, 32'(m) << 2);
    end
    // Output-disable mode must keep the compressed line released
    base = cdrv;
    repeat (600) @(posedge aclk);
    chk("compressed_drive", cdrv - base, 0);
    axw(pspt_pkg::OFS_CTRL, 32'h0000_0000, r);
    $display("test modes done");
    strobed <= 1'b1;
    axw(pspt_pkg::OFS_TX_PCM1, 32'h0000_00C3, r);
    repeat (1500) @(posedge aclk);
    chk("strobe1_oe_n", slot1_strobe_oe_n, 1);
    chk("half_clock_oe_n", half_rate_bit_clock_oe_n, 1);
    chk("delayed_frame_oe_n", delayed_frame_oe_n, 1);
    axr(pspt_pkg::OFS_STATUS, d, r);
    chk("status_strobed", d[0], 1);
    axr(pspt_pkg::OFS_RX_PCM1, d, r);
    chk("rx_pcm1", d, 32'h0000_00C3);
    axr(pspt_pkg::OFS_RX_PCM2, d, r);
    chk("rx_pcm2", d, 32'h0000_003C);
    $display("test strobed done");
    // Reset in mid-run returns outputs to idle
    aresetn <= 1'b0;
    strobed <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("awready", awready, 1);
    chk("bvalid", bvalid, 0);
    chk("strobe1_oe_n", slot1_strobe_oe_n, 1);
    chk("delayed_frame", delayed_frame_pulse_out_n, 1);
    aresetn <= 1'b1;
    axr(pspt_pkg::OFS_CTRL, d, r);
    chk("ctrl_reset", d, 32'h0000_0000);
    $display("test reset done");
    end_sim();
  end
endmodule
